// File: hw/pra_port_status_fsm.sv
// port-status machines for a primary-rate user port: access-network machine here,
// local-exchange machine in le_port_fsm; both links are brought out to ports
// assumes every input is a one-cycle pulse from logic on CLK_SYS
`timescale 1ns/1ps

// Operation
// - normal frames in 1.01, 1.21, 2.0, 3.0 and AN4; RAI in 1.02, 1.1, 1.22; NOF advances 1.01 and 1.21
// - FE201 moves to remote unblock or operational; operational answers FE202
// - FE203 blocks, keeps PL state, ignored when already blocked
// - management unblock request acts by state to unblock or block
// - management block sends FE204 in every state but AN4 and enters a blocked state
// - PL activate from local unblock, PL deactivate back to blocked
// - loss of signal or alignment reports error, sends FE204 unless already blocked, enters 1.02
// - FE-C/G/H like loss, FE-D/E/K end in 1.01, FE-I indicates only
// - a new digital-section event replaces the previous failure
// - unexpected events hold state; no-change events still emit outputs
// - D-channel block and unblock in operational; leaving operational removes it
// - unblock request in stable states answers without state change
// - loop request in blocked or remote unblock sends FE-Q/R, enters AN4
// - LE unblock request and FE202 drive coordinated unblocking
// - LE block sends FE203; FE204 blocks with indications
// - LE passes block request, grading, user and network failure up
// - LE D-channel block and unblock only in operational
// - LE verify request in operational resends FE201
module pra_port_status_fsm
    import pra_port_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // access-network event inputs
    input wire ds_event_type DS_EVENT,
    input wire an_mgmt_type AN_MGMT,
    input wire fe_type AN_RX,
    // access-network outputs
    output fe_type AN_TX,
    output an_ind_type AN_IND,
    output an_state_type AN_STATE,
    output logic AN_RAI,
    output logic AN_DCH_BLOCKED,
    output fault_type AN_FAULT,
    // local-exchange machine
    input wire le_mgmt_type LE_MGMT,
    input wire fe_type LE_RX,
    output fe_type LE_TX,
    output le_ind_type LE_IND,
    output le_state_type LE_STATE
);

    logic [AN_EV_NUM-1:0] pend;
    logic [AN_EV_NUM-1:0] arrive;
    logic [AN_EV_NUM-1:0] clear;
    logic [5:0] pick;
    logic take;
    an_ev_type sel;
    an_state_type next_state;
    fe_type next_tx;
    an_ind_type next_ind;
    fault_type next_fault;

    // blocked substates
    function automatic logic blocked(input an_state_type s);
        return s == AN_101 || s == AN_102;
    endfunction : blocked

    // blocked and remote-unblock states
    function automatic logic pre_op(input an_state_type s);
        return s == AN_101 || s == AN_102 || s == AN_121 || s == AN_122;
    endfunction : pre_op

    // failure code reported for a digital-section event
    function automatic fault_type cause_of(input an_ev_type e);
        case (e)
            EV_LOS: return FLT_LOS;
            EV_LFA: return FLT_LFA;
            EV_FC: return FLT_C;
            EV_FD: return FLT_D;
            EV_FE: return FLT_E;
            EV_FG: return FLT_G;
            EV_FH: return FLT_H;
            EV_FK: return FLT_K;
            EV_FL: return FLT_L;
            EV_FI: return FLT_I;
            default: return FLT_NONE;
        endcase
    endfunction : cause_of

    // peer elements that the machine acts on; any other received code is dropped
    assign arrive = {AN_RX == FE_208, AN_RX == FE_207, AN_RX == FE_203, AN_RX == FE_201,
        AN_MGMT, DS_EVENT};
    assign pick = first_set(32'(pend));
    assign take = pick[5];
    assign sel = an_ev_type'(pick[4:0]);
    assign clear = take ? (AN_EV_NUM'(1) << pick[4:0]) : '0;

    // pending events; an arrival in the serving cycle is kept, set beats clear
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) pend <= '0;
        else pend <= (pend & ~clear) | arrive;
    end

    // transition table; the AN4 group is left only by reset
    always_comb begin
        next_state = AN_STATE;
        next_tx = FE_NONE;
        next_ind = '0;
        next_fault = AN_FAULT;
        if (take && AN_STATE == AN_TEST) begin
            next_ind.unexpected = 1'b1;
        end else if (take) begin
            case (sel)
                EV_LOS, EV_LFA, EV_FC, EV_FG, EV_FH, EV_FL: begin
                    next_ind.err = 1'b1;
                    next_ind.cause = cause_of(sel);
                    next_fault = cause_of(sel);
                    if (!blocked(AN_STATE)) next_tx = FE_204;
                    next_state = AN_102;
                end
                EV_FD, EV_FE, EV_FK: begin
                    next_ind.err = 1'b1;
                    next_ind.cause = cause_of(sel);
                    next_fault = cause_of(sel);
                    if (!blocked(AN_STATE)) next_tx = FE_204;
                    next_state = AN_101;
                end
                EV_FI: begin
                    next_ind.err = 1'b1;
                    next_ind.cause = FLT_I;
                    next_fault = FLT_I;
                end
                EV_NOF: begin
                    next_fault = FLT_NONE;
                    next_ind.nof = pre_op(AN_STATE);
                    if (AN_STATE == AN_101) next_state = AN_102;
                    else if (AN_STATE == AN_121) next_state = AN_122;
                end
                EV_UBR: begin
                    case (AN_STATE)
                        AN_101: next_ind.bi = 1'b1;
                        AN_102: begin
                            next_tx = FE_202;
                            next_state = AN_11;
                        end
                        AN_11: next_tx = FE_202;
                        AN_121: begin
                            next_tx = FE_204;
                            next_ind.bi = 1'b1;
                            next_state = AN_101;
                        end
                        AN_122: begin
                            next_tx = FE_202;
                            next_ind.ubi = 1'b1;
                            next_state = AN_20;
                        end
                        AN_20: begin
                            next_tx = FE_202;
                            next_ind.ubi = 1'b1;
                        end
                        default: next_ind.pai = 1'b1;
                    endcase
                end
                EV_BI: begin
                    next_tx = FE_204;
                    if (AN_STATE == AN_121) next_state = AN_101;
                    else if (!blocked(AN_STATE)) next_state = AN_102;
                end
                EV_BR: begin
                    if (AN_STATE == AN_20) next_tx = FE_205;
                    else next_ind.unexpected = !blocked(AN_STATE);
                end
                EV_PAR: begin
                    if (AN_STATE == AN_11) begin
                        next_ind.pai = 1'b1;
                        next_state = AN_30;
                    end else next_ind.unexpected = (AN_STATE != AN_30);
                end
                EV_PDR: begin
                    if (AN_STATE == AN_30) begin
                        next_ind.pdi = 1'b1;
                        next_state = AN_102;
                    end else next_ind.unexpected = 1'b1;
                end
                EV_UF, EV_NF: begin
                    if (pre_op(AN_STATE)) next_tx = (sel == EV_UF) ? FE_209 : FE_210;
                    else next_ind.unexpected = 1'b1;
                end
                EV_GI: begin
                    if (AN_STATE == AN_20) next_tx = FE_206;
                    else next_ind.unexpected = 1'b1;
                end
                EV_LXAR: begin
                    if (pre_op(AN_STATE)) begin
                        next_tx = FE_QR;
                        next_state = AN_TEST;
                    end else next_ind.unexpected = 1'b1;
                end
                EV_201: begin
                    case (AN_STATE)
                        AN_101: begin
                            next_ind.ubr = 1'b1;
                            next_state = AN_121;
                        end
                        AN_102: begin
                            next_ind.ubr = 1'b1;
                            next_state = AN_122;
                        end
                        AN_121, AN_122: next_ind.ubr = 1'b1;
                        AN_20: begin
                            next_tx = FE_202;
                            next_ind.ubi = 1'b1;
                        end
                        default: begin
                            next_ind.ubi = 1'b1;
                            next_state = AN_20;
                        end
                    endcase
                end
                EV_203: begin
                    next_ind.bi = !blocked(AN_STATE);
                    if (AN_STATE == AN_121) next_state = AN_101;
                    else if (!blocked(AN_STATE) && AN_STATE != AN_30) next_state = AN_102;
                end
                EV_207, EV_208: begin
                    if (AN_STATE == AN_20) begin
                        next_ind.db = (sel == EV_207);
                        next_ind.du = (sel == EV_208);
                    end else next_ind.unexpected = 1'b1;
                end
                default: next_ind.unexpected = 1'b1;
            endcase
        end
    end

    // state, link element and indications are registered together
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            AN_STATE <= AN_RESET_STATE;
            AN_TX <= FE_NONE;
            AN_IND <= '0;
        end else begin
            AN_STATE <= next_state;
            AN_TX <= next_tx;
            AN_IND <= next_ind;
        end
    end

    // signal toward the user; registered from the next state to stay glitch free
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) AN_RAI <= 1'b1;
        else AN_RAI <= next_state == AN_102 || next_state == AN_11 || next_state == AN_122;
    end

    // only the latest digital-section report is held
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) AN_FAULT <= FLT_NONE;
        else AN_FAULT <= next_fault;
    end

    // d-channel block cannot outlive the operational state
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) AN_DCH_BLOCKED <= 1'b0;
        else if (next_state != AN_20) AN_DCH_BLOCKED <= 1'b0;
        else if (next_ind.db) AN_DCH_BLOCKED <= 1'b1;
        else if (next_ind.du) AN_DCH_BLOCKED <= 1'b0;
    end

    // exchange-side machine
    le_port_fsm u_le (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .mgmt(LE_MGMT),
        .rx(LE_RX),
        .tx(LE_TX),
        .ind(LE_IND),
        .state(LE_STATE)
    );

    default clocking an_cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    a_fail_priority: assert property (|pend[EV_NOF:EV_LOS] |-> take && sel <= EV_NOF) else $error("failure not served first");
    a_rai_state: assert property (AN_RAI == (AN_STATE inside {AN_102, AN_11, AN_122})) else $error("user signal does not match state");
    a_nof_advance: assert property (take && sel == EV_NOF && AN_STATE == AN_101 |=> AN_STATE == AN_102 && AN_IND.nof) else $error("normal frames did not advance");
    a_remote_unblock: assert property (take && sel == EV_201 && AN_STATE == AN_11 |=> AN_STATE == AN_20 && AN_IND.ubi) else $error("unblock not confirmed");
    a_peer_block: assert property (take && sel == EV_203 && AN_STATE == AN_20 |=> AN_STATE == AN_102 && AN_IND.bi) else $error("peer block wrong");
    a_local_unblock: assert property (take && sel == EV_UBR && AN_STATE == AN_102 |=> AN_STATE == AN_11 && AN_TX == FE_202 && AN_RAI) else $error("local unblock wrong");
    a_block_cmd: assert property (take && sel == EV_BI && AN_STATE != AN_TEST |=> AN_TX == FE_204 && blocked(AN_STATE)) else $error("block command wrong");
    a_pl_enter: assert property (take && sel == EV_PAR && AN_STATE == AN_11 |=> AN_STATE == AN_30 && AN_IND.pai && !AN_RAI) else $error("pl activation wrong");
    a_req_only_op: assert property (take && sel == EV_BR && AN_STATE == AN_11 |=> AN_TX == FE_NONE && AN_IND.unexpected) else $error("block request outside operational");
    a_loss_block: assert property (take && sel == EV_LOS && AN_STATE == AN_20 |=> AN_TX == FE_204 && AN_IND.err && AN_STATE == AN_102 && AN_FAULT == FLT_LOS) else $error("loss of signal wrong");
    a_dsfail_101: assert property (take && sel inside {EV_FD, EV_FE, EV_FK} && AN_STATE != AN_TEST |=> AN_STATE == AN_101) else $error("failure did not end in 1.01");
    a_unexp_hold: assert property (AN_IND.unexpected |-> $stable(AN_STATE) && AN_TX == FE_NONE) else $error("unexpected event changed state");
    a_dch_release: assert property (AN_STATE == AN_20 ##1 AN_STATE != AN_20 |-> !AN_DCH_BLOCKED) else $error("d-channel block outlived operational");
    a_op_check: assert property (take && sel == EV_UBR && AN_STATE == AN_20 |=> AN_STATE == AN_20 && AN_TX == FE_202 && AN_IND.ubi) else $error("status check wrong");
    a_loop_entry: assert property (take && sel == EV_LXAR && pre_op(AN_STATE) |=> AN_TX == FE_QR && AN_STATE == AN_TEST) else $error("loop request wrong");

    c_unblock: cover property (AN_STATE == AN_11 ##[1:20] AN_STATE == AN_20);
    c_remote: cover property (AN_STATE == AN_122 ##[1:20] AN_STATE == AN_20);
    c_pl_mode: cover property (AN_STATE == AN_30 ##[1:20] AN_IND.pdi);
    c_dch_drop: cover property (AN_DCH_BLOCKED ##1 !AN_DCH_BLOCKED && AN_STATE != AN_20);

endmodule : pra_port_status_fsm

// File: hw/pra_port_pkg.sv
// types, event orderings and reset values shared by the port-status machines
// assumes all event pulses come from logic on the same system clock
package pra_port_pkg;

    // port states of the access-network machine; AN_TEST stands for the AN4 group
    typedef enum logic [2:0] {AN_101, AN_102, AN_11, AN_121, AN_122, AN_20, AN_30, AN_TEST}
        an_state_type;
    typedef enum logic [2:0] {LE_10, LE_11, LE_12, LE_20} le_state_type;

    // control function elements on the link between the machines
    typedef enum logic [3:0] {FE_NONE, FE_201, FE_202, FE_203, FE_204, FE_205, FE_206,
        FE_207, FE_208, FE_209, FE_210, FE_QR} fe_type;

    // digital-section failure reported to management
    typedef enum logic [3:0] {FLT_NONE, FLT_LOS, FLT_LFA, FLT_C, FLT_D, FLT_E, FLT_G,
        FLT_H, FLT_I, FLT_K, FLT_L} fault_type;

    // event order is service priority: failures, then management, then peer
    typedef enum logic [4:0] {EV_LOS, EV_LFA, EV_FC, EV_FD, EV_FE, EV_FG, EV_FH, EV_FK,
        EV_FL, EV_FI, EV_NOF, EV_UBR, EV_BI, EV_BR, EV_PAR, EV_PDR, EV_UF, EV_NF, EV_GI,
        EV_LXAR, EV_201, EV_203, EV_207, EV_208} an_ev_type;
    typedef enum logic [4:0] {LV_UBR, LV_BI, LV_DB, LV_DU, LV_202, LV_204, LV_205, LV_206,
        LV_209, LV_210} le_ev_type;

    // last field is the lowest bit, so the field order matches the event order
    typedef struct packed {
        logic nof, fe_i, fe_l, fe_k, fe_h, fe_g, fe_e, fe_d, fe_c, lfa, los;
    } ds_event_type;
    typedef struct packed {
        logic lxar, gi, nf, uf, pdr, par, br, bi, ubr;
    } an_mgmt_type;
    typedef struct packed {
        logic du, db, bi, ubr;
    } le_mgmt_type;

    // one-cycle indications toward each management
    typedef struct packed {
        logic ubr, ubi, bi, pai, pdi, nof, err, db, du, unexpected;
        fault_type cause;
    } an_ind_type;
    typedef struct packed {
        logic ubr, ubi, bi, br, gi, uf, nf, ai, di, unexpected;
    } le_ind_type;

    localparam int AN_EV_NUM = 24;
    localparam int LE_EV_NUM = 10;
    localparam an_state_type AN_RESET_STATE = AN_102;
    localparam le_state_type LE_RESET_STATE = LE_10;

    // lowest set bit wins; bit 5 of the result says whether any was set
    function automatic logic [5:0] first_set(input logic [31:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction : first_set

endpackage : pra_port_pkg

// File: hw/le_port_fsm.sv
// local-exchange side port-status machine for one primary-rate user port
// assumes management pulses and link elements are synchronous to clk
`timescale 1ns/1ps
module le_port_fsm
    import pra_port_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // management and link inputs
    input wire le_mgmt_type mgmt,
    input wire fe_type rx,
    // registered outputs
    output fe_type tx,
    output le_ind_type ind,
    output le_state_type state
);

    logic [LE_EV_NUM-1:0] pend;
    logic [LE_EV_NUM-1:0] arrive;
    logic [LE_EV_NUM-1:0] clear;
    logic [5:0] pick;
    logic take;
    le_ev_type sel;
    le_state_type next_state;
    fe_type next_tx;
    le_ind_type next_ind;

    // management first, then peer elements
    assign arrive = {rx == FE_210, rx == FE_209, rx == FE_206, rx == FE_205, rx == FE_204,
        rx == FE_202, mgmt};
    assign pick = first_set(32'(pend));
    assign take = pick[5];
    assign sel = le_ev_type'(pick[4:0]);
    assign clear = take ? (LE_EV_NUM'(1) << pick[4:0]) : '0;

    // a new arrival beats the clear of the same bit
    always_ff @(posedge clk) begin
        if (rst) pend <= '0;
        else pend <= (pend & ~clear) | arrive;
    end

    // transition table
    always_comb begin
        next_state = state;
        next_tx = FE_NONE;
        next_ind = '0;
        if (take) begin
            case (sel)
                LV_UBR: begin
                    next_tx = FE_201;
                    if (state == LE_10) next_state = LE_11;
                    else if (state == LE_12) begin
                        next_ind.ai = 1'b1;
                        next_state = LE_20;
                    end
                end
                LV_BI: begin
                    next_tx = FE_203;
                    next_state = LE_10;
                end
                LV_202: begin
                    case (state)
                        LE_10: begin
                            next_ind.ubr = 1'b1;
                            next_state = LE_12;
                        end
                        LE_11: begin
                            next_ind.ai = 1'b1;
                            next_state = LE_20;
                        end
                        LE_12: next_ind.ubr = 1'b1;
                        default: next_ind.ubi = 1'b1;
                    endcase
                end
                LV_204: begin
                    if (state != LE_10) begin
                        next_ind.bi = 1'b1;
                        next_ind.di = (state == LE_20);
                        next_state = LE_10;
                    end
                end
                LV_205: next_ind.br = (state == LE_20);
                LV_206: begin
                    next_ind.gi = (state == LE_20);
                    next_ind.unexpected = (state != LE_20);
                end
                LV_209, LV_210: begin
                    if (state == LE_10 || state == LE_11) begin
                        next_ind.uf = (sel == LV_209);
                        next_ind.nf = (sel == LV_210);
                    end else next_ind.unexpected = 1'b1;
                end
                LV_DB, LV_DU: begin
                    if (state == LE_20) next_tx = (sel == LV_DB) ? FE_207 : FE_208;
                    else next_ind.unexpected = 1'b1;
                end
                default: next_ind.unexpected = 1'b1;
            endcase
        end
    end

    // state and outputs move together
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= LE_RESET_STATE;
            tx <= FE_NONE;
            ind <= '0;
        end else begin
            state <= next_state;
            tx <= next_tx;
            ind <= next_ind;
        end
    end

    default clocking le_cb @(posedge clk); endclocking
    default disable iff (rst);

    a_le_verify: assert property (take && sel == LV_UBR && state == LE_20 |=> tx == FE_201 && state == LE_20) else $error("verify did not resend unblock");
    a_le_block: assert property (take && sel == LV_204 && state == LE_20 |=> ind.bi && ind.di && state == LE_10) else $error("block from operational wrong");
    a_le_remote: assert property (take && sel == LV_202 && state == LE_10 |=> ind.ubr && state == LE_12) else $error("remote unblock not entered");
    a_le_dch: assert property (take && sel == LV_DB && state != LE_20 |=> tx == FE_NONE && ind.unexpected) else $error("d-channel block outside operational");

endmodule : le_port_fsm

// File: verif/pra_link_model.sv
// link model: carries elements between the access-network and exchange machines
// assumes both machine links run on the system clock and idle at FE_NONE
`timescale 1ns/1ps
module pra_link_model
    import pra_port_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // elements sent by each machine
    input wire fe_type an_tx,
    input wire fe_type le_tx,
    // elements delivered to each machine
    output fe_type an_rx,
    output fe_type le_rx
);
    // one cycle of transit each way; a real link is never faster, so no same-cycle reply
    always_ff @(posedge clk) begin
        if (rst) begin
            an_rx <= FE_NONE;
            le_rx <= FE_NONE;
        end else begin
            an_rx <= le_tx;
            le_rx <= an_tx;
        end
    end
endmodule : pra_link_model

// File: verif/pra_port_status_fsm_bench.sv
// testbench for the port-status machines, linked through pra_link_model
// assumes outputs settle one edge after an event is served
`timescale 1ns/1ps
module pra_port_status_fsm_bench
    import pra_port_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1;
    ds_event_type ds = '0;
    an_mgmt_type am = '0;
    le_mgmt_type lm = '0;
    fe_type an_rx, an_tx, le_rx, le_tx;
    an_ind_type ai;
    le_ind_type li;
    an_state_type ast;
    le_state_type lst;
    logic rai, dch;
    fault_type flt;
    int failures = 0, compares = 0;
    // 25 MHz system clock
    always #20 clk = ~clk;
    pra_port_status_fsm dut (.CLK_SYS(clk), .SYS_RST(rst), .DS_EVENT(ds), .AN_MGMT(am),
        .AN_RX(an_rx), .AN_TX(an_tx), .AN_IND(ai), .AN_STATE(ast), .AN_RAI(rai),
        .AN_DCH_BLOCKED(dch), .AN_FAULT(flt), .LE_MGMT(lm), .LE_RX(le_rx), .LE_TX(le_tx),
        .LE_IND(li), .LE_STATE(lst));
    pra_link_model link (.clk(clk), .rst(rst), .an_tx(an_tx), .le_tx(le_tx), .an_rx(an_rx),
        .le_rx(le_rx));
    task check(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : check
    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    // one-cycle pulse on falling edges; returns where the served outputs are visible
    task pulse(input logic [8:0] m, input logic [10:0] d, input logic [3:0] l);
        @(negedge clk);
        am = m; ds = d; lm = l;
        @(negedge clk);
        am = '0; ds = '0; lm = '0;
        @(negedge clk);
    endtask : pulse
    task end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    // coordinated unblock, then a verify request from the exchange side
    task t_unblock;
        pulse(9'h001, 11'h000, 4'h0);
        check(an_tx, FE_202); check(ast, AN_11); check(rai, 1'b1);
        idle(3); check(lst, LE_12); check(li.ubr, 1'b1);
        pulse(9'h000, 11'h000, 4'h1);
        check(le_tx, FE_201); check(lst, LE_20); check(li.ai, 1'b1);
        idle(3); check(ast, AN_20); check(ai.ubi, 1'b1); check(rai, 1'b0);
        pulse(9'h000, 11'h000, 4'h1); check(le_tx, FE_201);
        idle(3); check(an_tx, FE_202); check(ast, AN_20);
        idle(3); check(li.ubi, 1'b1);
        $display("unblock test done");
    endtask : t_unblock
    // remote D-channel block, lifted when the access side blocks the port
    task t_block;
        pulse(9'h000, 11'h000, 4'h4); check(le_tx, FE_207);
        idle(3); check(ai.db, 1'b1); check(dch, 1'b1);
        pulse(9'h002, 11'h000, 4'h0);
        check(an_tx, FE_204); check(ast, AN_102); check(dch, 1'b0);
        idle(3); check(lst, LE_10); check(li.di, 1'b1); check(li.bi, 1'b1);
        $display("block test done");
    endtask : t_block
    // failures, priority of simultaneous events, permanent-line mode, unexpected event
    task t_fault;
        pulse(9'h000, 11'h001, 4'h0);
        check(ai.err, 1'b1); check(ai.cause, FLT_LOS); check(an_tx, FE_NONE);
        pulse(9'h000, 11'h008, 4'h0);
        check(ast, AN_101); check(flt, FLT_D); check(rai, 1'b0);
        pulse(9'h001, 11'h002, 4'h0);
        check(ai.cause, FLT_LFA); check(ast, AN_102); check(an_tx, FE_NONE);
        idle(1); check(an_tx, FE_202); check(ast, AN_11);
        pulse(9'h008, 11'h000, 4'h0); check(ast, AN_30); check(ai.pai, 1'b1);
        pulse(9'h010, 11'h000, 4'h0); check(ast, AN_102); check(ai.pdi, 1'b1);
        pulse(9'h080, 11'h000, 4'h0); check(ai.unexpected, 1'b1); check(ast, AN_102);
        $display("fault test done");
    endtask : t_fault
    // failure clearing, exchange block, user failure, loop mode, then a mid-run reset
    task t_loop;
        pulse(9'h000, 11'h400, 4'h0); check(ai.nof, 1'b1);
        check(flt, FLT_NONE);
        pulse(9'h000, 11'h200, 4'h0); check(ai.cause, FLT_I); check(ast, AN_102);
        pulse(9'h000, 11'h000, 4'h2); check(le_tx, FE_203); check(lst, LE_10);
        idle(3); check(ai, 16'h0000); check(ast, AN_102);
        pulse(9'h020, 11'h000, 4'h0); check(an_tx, FE_209);
        idle(3); check(li.uf, 1'b1);
        pulse(9'h100, 11'h000, 4'h0); check(an_tx, FE_QR); check(ast, AN_TEST);
        pulse(9'h002, 11'h000, 4'h0); check(ai.unexpected, 1'b1);
        check(an_tx, FE_NONE); check(ast, AN_TEST);
        @(negedge clk);
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        check(ast, AN_102); check(rai, 1'b1); check(lst, LE_10); check(flt, FLT_NONE);
        $display("loop test done");
    endtask : t_loop
    // the whole run is under a hundred cycles, so 3000 means a hang
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        end_of_test();
    end
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check(ast, AN_102); check(rai, 1'b1); check(lst, LE_10); check(flt, FLT_NONE);
        t_unblock();
        t_block();
        t_fault();
        t_loop();
        end_of_test();
    end
endmodule : pra_port_status_fsm_bench
